// ===== rrcs_pkg.sv
package rrcs_pkg;

  localparam int NUM_REF = 2;
  localparam int BANK_W  = 6;
  localparam int RATIO_W = 4;
  localparam int CNT_W   = 4;

  // positions inside the synchroniser vector
  localparam int SY_REF0 = 0;
  localparam int SY_REF1 = 1;
  localparam int SY_FB   = 2;
  localparam int SY_CTRL = 3;
  localparam int CTRL_W  = 9;
  localparam int SYNC_W  = SY_CTRL + CTRL_W;

  // a reference is failed after this many feedback rising edges without
  // one of its own rising edges
  localparam logic [CNT_W-1:0] FAIL_WIN = 4'h4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

  // bank A half period in clock cycles, indexed by ratio bits 0..2;
  // a faster multiplier maps to a shorter half period
  localparam logic [CNT_W-1:0] A_HALF [8] = '{
    4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h8, 4'h8, 4'h8
  };

  localparam logic FLAG_IDLE = 1'b1;  // fail flags are active low
  localparam logic SEL_FIRST = 1'b0;

  typedef struct packed {
    logic             auto_mode;
    logic             bypass;
    logic             primary_sel;
    logic             clear_n;
    logic [0:RATIO_W-1] ratio;
    logic             off;
  } rrcs_ctrl_type;

endpackage : rrcs_pkg

// ===== rrcs_refs.sv
`timescale 1ns/1ps
module rrcs_refs #(
  parameter int HALF_NS = 320
) (
  input  wire logic run_first,
  input  wire logic run_second,
  input  wire logic coast,
  input  wire logic loop_feedback_out,
  output logic      ref_in_first,
  output logic      ref_in_second,
  output logic      loop_feedback_in
);
  logic vco;
  // a stopped source freezes at its last level, like a dead oscillator;
  // the offset keeps the edges clear of the system clock edge
  initial begin
    ref_in_first  = 1'b0;
    ref_in_second = 1'b0;
    vco           = 1'b0;
    #13;
    forever begin
      #(HALF_NS);
      vco = ~vco;
      if (run_first) ref_in_first = ~ref_in_first;
      if (run_second) ref_in_second = ~ref_in_second;
    end
  end
  // coast stands in for a loop that keeps running after its reference dies
  assign loop_feedback_in = coast ? vco : loop_feedback_out;
endmodule : rrcs_refs

// ===== rrcs_switch.sv
`timescale 1ns/1ps

module rrcs_switch (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       ref_in_first,
  input  wire logic                       ref_in_second,
  input  wire logic                       loop_feedback_in,
  input  wire logic                       switch_mode_choice,
  input  wire logic                       bypass_select,
  input  wire logic                       primary_select,
  input  wire logic                       alarm_clear_n,
  input  wire logic [0:rrcs_pkg::RATIO_W-1] ratio_choice,
  input  wire logic                       output_off_reset,
  output logic      [rrcs_pkg::BANK_W-1:0]  bank_first_outs,
  output logic      [rrcs_pkg::BANK_W-1:0]  bank_second_outs,
  output logic                            bank_oe_n,
  output logic                            loop_feedback_out,
  output logic                            fail_flag_first_n,
  output logic                            fail_flag_second_n,
  output logic                            active_ref_indicator
);

  logic [rrcs_pkg::SYNC_W-1:0]  pins;
  logic [rrcs_pkg::SYNC_W-1:0]  s1_r;
  logic [rrcs_pkg::SYNC_W-1:0]  s2_r;
  rrcs_pkg::rrcs_ctrl_type      ctrl;
  logic [rrcs_pkg::NUM_REF-1:0] ref_s;
  logic [rrcs_pkg::NUM_REF-1:0] ref_prev_r;
  logic [rrcs_pkg::NUM_REF-1:0] ref_rise;
  logic [rrcs_pkg::NUM_REF-1:0] miss;
  logic [rrcs_pkg::NUM_REF-1:0] flag_n_r;
  logic                         fb_prev_r;
  logic                         fb_rise;
  logic                         clr_prev_r;
  logic                         clear_pulse;
  logic                         off;
  logic                         active_r;
  logic [rrcs_pkg::CNT_W-1:0]   a_half;
  logic [rrcs_pkg::CNT_W-1:0]   a_cnt_r;
  logic [rrcs_pkg::BANK_W-1:0]  a_out_r;
  logic [rrcs_pkg::BANK_W-1:0]  b_out_r;
  logic                         oe_n_r;
  logic                         fb_out_r;
  logic                         a_toggle;

  assign pins = {switch_mode_choice, bypass_select, primary_select,
                 alarm_clear_n, ratio_choice, output_off_reset,
                 loop_feedback_in, ref_in_second, ref_in_first};

  // every pin is asynchronous to clock; two stages before any use.
  // the output off stage starts set so the banks cannot be enabled for
  // the two cycles it takes the real pin level to arrive
  for (genvar i = 0; i < rrcs_pkg::SYNC_W; i++) begin : g_sync
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        s1_r[i] <= (i == rrcs_pkg::SY_CTRL);
        s2_r[i] <= (i == rrcs_pkg::SY_CTRL);
      end else begin
        s1_r[i] <= pins[i];
        s2_r[i] <= s1_r[i];
      end
    end
  end

  assign ctrl  = rrcs_pkg::rrcs_ctrl_type'(
                   s2_r[rrcs_pkg::SYNC_W-1:rrcs_pkg::SY_CTRL]);
  assign ref_s = {s2_r[rrcs_pkg::SY_REF1], s2_r[rrcs_pkg::SY_REF0]};
  assign off   = ctrl.off;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ref_prev_r <= '0;
      fb_prev_r  <= 1'b0;
      // starts low: the synchroniser's reset level must not read as a clear
      clr_prev_r <= 1'b0;
    end else begin
      ref_prev_r <= ref_s;
      fb_prev_r  <= s2_r[rrcs_pkg::SY_FB];
      clr_prev_r <= ctrl.clear_n;
    end
  end

  assign ref_rise    = ref_s & ~ref_prev_r;
  assign fb_rise     = s2_r[rrcs_pkg::SY_FB] & ~fb_prev_r;
  assign clear_pulse = clr_prev_r & ~ctrl.clear_n;

  // per-reference watchdog clocked by feedback edges; if feedback stops
  // nothing is declared failed, which is why the loop must be closed
  for (genvar r = 0; r < rrcs_pkg::NUM_REF; r++) begin : g_watch
    logic [rrcs_pkg::CNT_W-1:0] miss_cnt_r;

    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        miss_cnt_r <= rrcs_pkg::CNT_ZERO;
      end else if (off || ref_rise[r]) begin
        miss_cnt_r <= rrcs_pkg::CNT_ZERO;
      end else if (fb_rise && miss_cnt_r != rrcs_pkg::FAIL_WIN) begin
        miss_cnt_r <= miss_cnt_r + rrcs_pkg::CNT_ONE;
      end
    end

    assign miss[r] = (miss_cnt_r == rrcs_pkg::FAIL_WIN);

    // failure beats a clear arriving in the same cycle
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        flag_n_r[r] <= rrcs_pkg::FLAG_IDLE;
      end else if (off) begin
        flag_n_r[r] <= rrcs_pkg::FLAG_IDLE;
      end else if (miss[r]) begin
        flag_n_r[r] <= ~rrcs_pkg::FLAG_IDLE;
      end else if (clear_pulse) begin
        flag_n_r[r] <= rrcs_pkg::FLAG_IDLE;
      end
    end
  end

  // reference choice; the other input is taken when the active one misses and it is live, so a
  // restored input can be returned to
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      active_r <= rrcs_pkg::SEL_FIRST;
    end else if (off || clear_pulse) begin
      active_r <= ctrl.primary_sel;
    end else if (!ctrl.auto_mode || ctrl.bypass) begin
      active_r <= ctrl.primary_sel;
    end else if (miss[active_r] && !miss[~active_r]) begin
      active_r <= ~active_r;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fb_out_r <= 1'b0;
      oe_n_r   <= 1'b1;
    end else begin
      fb_out_r <= ref_s[active_r];  // not tristated by output disable
      oe_n_r   <= off;
    end
  end

  assign a_half   = rrcs_pkg::A_HALF[{ctrl.ratio[0], ctrl.ratio[1],
                                      ctrl.ratio[2]}];
  assign a_toggle = (a_cnt_r >= a_half - rrcs_pkg::CNT_ONE);

  // dividers run on without restart across a switch so the outputs glide
  // rather than jump when the reference changes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      a_cnt_r <= rrcs_pkg::CNT_ZERO;
      a_out_r <= '0;
      b_out_r <= '0;
    end else if (off) begin
      a_cnt_r <= rrcs_pkg::CNT_ZERO;
      a_out_r <= '0;
      b_out_r <= '0;
    end else if (ctrl.bypass) begin
      a_cnt_r <= rrcs_pkg::CNT_ZERO;
      a_out_r <= {rrcs_pkg::BANK_W{ref_s[active_r]}};
      b_out_r <= {rrcs_pkg::BANK_W{ref_s[active_r]}};
    end else if (a_toggle) begin
      a_cnt_r <= rrcs_pkg::CNT_ZERO;
      a_out_r <= {rrcs_pkg::BANK_W{~a_out_r[0]}};
      if (!ctrl.ratio[3]) begin
        b_out_r <= {rrcs_pkg::BANK_W{~a_out_r[0]}};
      end else if (!a_out_r[0]) begin
        b_out_r <= {rrcs_pkg::BANK_W{~b_out_r[0]}};
      end
    end else begin
      a_cnt_r <= a_cnt_r + rrcs_pkg::CNT_ONE;
    end
  end

  assign bank_first_outs      = a_out_r;
  assign bank_second_outs     = b_out_r;
  assign bank_oe_n            = oe_n_r;
  assign loop_feedback_out    = fb_out_r;
  assign fail_flag_first_n    = flag_n_r[0];
  assign fail_flag_second_n   = flag_n_r[1];
  assign active_ref_indicator = active_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_off_tristate: assert property (off |=> bank_oe_n)
    else $error("outputs not disabled by output off");
  chk_off_divider: assert property (off |=> a_out_r == '0 && b_out_r == '0)
    else $error("dividers not reset by output off");
  chk_fail_flag: assert property (miss[0] && !off |=> !fail_flag_first_n)
    else $error("first failure flag not raised");
  chk_fail_second: assert property (miss[1] && !off |=> !fail_flag_second_n)
    else $error("second failure flag not raised");
  chk_clear_flags: assert property (
    clear_pulse && miss == '0 && !off
    |=> fail_flag_first_n && fail_flag_second_n
        && active_ref_indicator == $past(ctrl.primary_sel))
    else $error("alarm clear did not restore flags");
  chk_manual_select: assert property (
    !ctrl.auto_mode && !off ##1 !ctrl.auto_mode
    |-> active_ref_indicator == $past(ctrl.primary_sel))
    else $error("manual mode ignored primary select");
  chk_bypass_static: assert property (
    ctrl.bypass && !off |=> a_out_r[0] == $past(ref_s[active_r]))
    else $error("bypass did not pass reference");
  chk_failover_switch: assert property (
    ctrl.auto_mode && !ctrl.bypass && !off && !clear_pulse
    && miss[active_r] && !miss[~active_r]
    |=> active_r != $past(active_r))
    else $error("no failover on active failure");
  chk_bank_b_half: assert property (
    ctrl.ratio[3] && !ctrl.bypass && !off && !$past(off)
    && $rose(b_out_r[0]) |-> $rose(a_out_r[0]))
    else $error("bank two rose off a bank one edge");
  chk_divider_bound: assert property (
    !ctrl.bypass && !off && $stable(a_half) |=> a_cnt_r < $past(a_half))
    else $error("bank one counter past its half period");

  cov_failover: cover property (
    ctrl.auto_mode && !ctrl.bypass ##1 $changed(active_r) && !off);
  cov_clear: cover property (!fail_flag_first_n ##[1:50] clear_pulse);
  cov_bypass: cover property (ctrl.bypass && !off ##1 $rose(a_out_r[0]));

endmodule : rrcs_switch

// ===== rrcs_switch_tb_top.sv
`timescale 1ns/1ps
module rrcs_switch_tb_top;
  logic       clock, rst, run1, run2, coast, mode, byp, psel, clr_n, off;
  logic [0:3] ratio;
  logic       r1, r2, fbi, fbo, oe_n, f1_n, f2_n, ind;
  logic [5:0] ba, bb;
  int         error_cnt = 0, cmp_count = 0, cyc = 0;

  rrcs_refs rrcs_refs_inst (.run_first(run1), .run_second(run2),
    .coast(coast), .loop_feedback_out(fbo), .ref_in_first(r1),
    .ref_in_second(r2), .loop_feedback_in(fbi));
  rrcs_switch rrcs_switch_inst (.clock(clock), .rst(rst),
    .ref_in_first(r1), .ref_in_second(r2), .loop_feedback_in(fbi),
    .switch_mode_choice(mode), .bypass_select(byp),
    .primary_select(psel), .alarm_clear_n(clr_n), .ratio_choice(ratio),
    .output_off_reset(off), .bank_first_outs(ba), .bank_second_outs(bb),
    .bank_oe_n(oe_n), .loop_feedback_out(fbo), .fail_flag_first_n(f1_n),
    .fail_flag_second_n(f2_n), .active_ref_indicator(ind));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock)
    if (++cyc == 20000) begin
      error_cnt++;
      test_done();
    end

  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task clr;
    clr_n = 1'b0;
    step(6);
    clr_n = 1'b1;
    step(4);
    chk("flags clr", {f1_n, f2_n}, 8'h03);
  endtask : clr
  task test_done;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  task t_reset;
    psel = 1'b1;
    step(4);
    chk("oe off", oe_n, 8'h01);
    chk("bank off", {ba, 2'h0}, 8'h00);
    chk("ind off", ind, psel);
    psel = 1'b0;
    step(36);
    chk("ind psel0", ind, 8'h00);
    off = 1'b0;
    step(6);
    chk("oe on", oe_n, 8'h00);
  endtask : t_reset
  task t_side_fail;
    run2 = 1'b0;
    step(100);
    chk("flags side", {f1_n, f2_n}, 8'h02);
    chk("ind side", ind, 8'h00);
    run2 = 1'b1;
    step(40);
    clr();
  endtask : t_side_fail
  task t_failover;
    logic f;
    coast = 1'b1;
    run1 = 1'b0;
    step(100);
    chk("flags fo", {f1_n, f2_n}, 8'h01);
    chk("ind fo", ind, 8'h01);
    f = fbo;
    step(8);
    chk("fb out fo", fbo, !f);
    run1 = 1'b1;
    step(40);
    run2 = 1'b0;
    step(100);
    chk("ind back", ind, 8'h00);
    run2 = 1'b1;
    step(40);
    clr();
    chk("ind clr", ind, 8'h00);
    coast = 1'b0;
  endtask : t_failover
  task t_manual;
    mode = 1'b0;
    coast = 1'b1;
    run1 = 1'b0;
    step(100);
    chk("ind man", ind, 8'h00);
    chk("flag man", f1_n, 8'h00);
    psel = 1'b1;
    step(4);
    chk("ind psel1", ind, 8'h01);
    run1 = 1'b1;
    psel = 1'b0;
    step(40);
    clr();
    mode = 1'b1;
  endtask : t_manual
  task t_bypass;
    byp = 1'b1;
    run1 = 1'b0;
    step(100);
    chk("byp a", ba, {6{r1}});
    chk("byp b", bb, {6{r1}});
    chk("byp ind", ind, 8'h00);
    run1 = 1'b1;
    byp = 1'b0;
    coast = 1'b0;
    step(40);
    clr();
  endtask : t_bypass
  task meas(input logic sel, output int n);
    logic p;
    for (int k = 0; k < 2; k++) begin
      p = sel ? bb[0] : ba[0];
      n = 0;
      while ((sel ? bb[0] : ba[0]) === p && n < 40) begin
        step(1);
        n++;
      end
    end
  endtask : meas
  task t_ratio;
    int n;
    logic [3:0] h;
    for (int i = 0; i < 5; i++)
      for (int b = 0; b < 2; b++) begin
        ratio = {3'(i), 1'(b)};
        h = rrcs_pkg::A_HALF[i];
        step(40);
        meas(1'b0, n);
        chk("half a", 8'(n), 8'(h));
        chk("six a", ba ^ {6{ba[0]}}, 8'h00);
        meas(1'b1, n);
        chk("half b", 8'(n), b ? 8'(2 * h) : 8'(h));
        chk("align", ba[0], b ? 8'h01 : 8'(bb[0]));
      end
  endtask : t_ratio

  initial begin
    rst = 1'b1;
    off = 1'b1;
    {run1, run2, mode, clr_n} = 4'hF;
    {coast, byp, psel} = 3'h0;
    ratio = 4'h0;
    repeat (20) @(posedge clock);
    #1;
    rst = 1'b0;
    t_reset();
    t_side_fail();
    t_failover();
    t_manual();
    t_bypass();
    t_ratio();
    test_done();
  end
endmodule : rrcs_switch_tb_top
